// file: hdl/ksp_pkg.sv
// Purpose: shared constants and carriers for the key-scan and sense ports
// Assumes: classic wishbone, 32-bit data, byte addresses
// Notes: control register layout and offsets are fixed here
`default_nettype none
package ksp_pkg;
  localparam logic [3:0] KSP_OFF_SCAN    = 4'h0;
  localparam logic [3:0] KSP_OFF_STATUS  = 4'h4;
  localparam logic [3:0] KSP_OFF_CTRL    = 4'h8;
  localparam logic [7:0] KSP_SCAN_RESET  = 8'hff;
  localparam logic [7:0] KSP_CTRL_RESET  = 8'h26;
  localparam int KSP_B_S0_MODE   = 0;
  localparam int KSP_B_SCAN_OUT  = 1;
  localparam int KSP_B_IND_OUT   = 2;
  localparam int KSP_B_WAKE_EN   = 3;
  localparam int KSP_B_S01_PD    = 4;
  localparam int KSP_B_KEY_PD    = 5;
  localparam int KSP_B_S3_PD     = 6;
  localparam int KSP_B_S3_MODE   = 7;
  localparam int KSP_B_ST_S3     = 0;
  localparam int KSP_B_ST_WAKE   = 1;
  localparam int KSP_B_ST_S0     = 2;
  localparam int KSP_B_ST_IND    = 3;
  localparam int KSP_B_ST_KEY    = 4;

  typedef struct packed {
    logic [3:0] key;
    logic       first_sense;
    logic       indicator;
    logic       wake;
    logic       second_sense;
  } ksp_pins_type;

  typedef struct packed {
    logic [3:0] key;
    logic       first_sense;
    logic       indicator;
    logic       wake;
    logic       second_sense;
  } ksp_pulls_type;
endpackage : ksp_pkg
`default_nettype wire

// file: hdl/ksp_status_mux.sv
// Purpose: assembles the read-only pin status byte
// Assumes: pin inputs already synchronous
// Notes: purely combinational
`default_nettype none
module ksp_status_mux
  import ksp_pkg::*;
#(
  parameter bit HAS_SECOND_SENSE = 1'b1
) (
  input  wire ksp_pins_type pins_i,
  input  wire logic [7:0]   ctrl_i,
  output logic [7:0]        status_o
);
  wire s0_bit = ctrl_i[KSP_B_S0_MODE] ? pins_i.first_sense : 1'b1; // R8
  wire s3_bit = !HAS_SECOND_SENSE ? 1'b1 :                          // R18
                (ctrl_i[KSP_B_S3_MODE] ? pins_i.second_sense : 1'b0); // R17
  // indicator is read from the pin in both directions
  assign status_o = {pins_i.key, pins_i.indicator, s0_bit,          // R6 R10 R19
                     pins_i.wake, s3_bit};
endmodule : ksp_status_mux
`default_nettype wire

// file: hdl/ksp_ports.sv
// Purpose: key-scan port, key input port and sense pins with register access
// Assumes: 100 MHz ref_clk_i, classic wishbone slave, pins synchronous
// Notes: control register sits at its own offset; ack after one cycle
//
// Contract
// R1 - 8-bit key-scan port direction from control bit 1.
// R2 - scan read gives pins in input mode, latch in output mode.
// R3 - scan write always updates the latch, any direction.
// R4 - reset: scan port output mode, latch all ones.
// R5 - scan pull-downs only active in input mode.
// R6 - 4-bit key input levels read in status bits 7 to 4.
// R7 - key pull-downs together by control bit 5, on after reset.
// R8 - first sense enabled by bit 0; off reads one; reset off.
// R9 - bit 4 pulls first sense and indicator, only as inputs.
// R10 - indicator direction by bit 2; its level always readable.
// R11 - indicator output drops pull-down and shows timer display signal.
// R12 - reset: indicator in output mode driving high.
// R13 - bit 3 enables wake input as stop release, with pull-down.
// R14 - wake disabled: readable, no pull-down, never ends stop.
// R15 - reset: wake input with wake disabled, floating.
// R16 - second sense enabled by bit 7, pull-down by bit 6.
// R17 - second sense off floats and reads zero; reset off.
// R18 - without second sense, status bit 0 reads one.
// R19 - status register read-only: keys, indicator, sense, wake bits.
// R20 - outside circuit holds a key input low at power-on release.
// R21 - control resets to 0x26, other bits cleared.
// R22 - writes to status register are ignored.
`default_nettype none
module ksp_ports
  import ksp_pkg::*;
#(
  parameter bit HAS_SECOND_SENSE = 1'b1,
  parameter int SCAN_WIDTH       = 8
) (
  input  wire logic                  ref_clk_i,
  input  wire logic                  nrst_i,
  // wishbone
  input  wire logic                  cyc_i,
  input  wire logic                  stb_i,
  input  wire logic                  we_i,
  input  wire logic [3:0]            adr_i,
  input  wire logic [3:0]            sel_i,
  input  wire logic [31:0]           dat_i,
  output logic [31:0]                dat_o,
  output logic                       ack_o,
  // pins
  input  wire logic [SCAN_WIDTH-1:0] scan_in_i,
  output logic [SCAN_WIDTH-1:0]      scan_out_o,
  output logic [SCAN_WIDTH-1:0]      scan_oe_o,
  output logic [SCAN_WIDTH-1:0]      scan_pd_o,
  input  wire ksp_pins_type          pins_i,
  output ksp_pulls_type              pulls_o,
  input  wire logic                  tx_display_i,
  output logic                       indicator_out_o,
  output logic                       indicator_oe_o,
  output logic                       first_sense_in_en_o,
  output logic                       second_sense_in_en_o,
  input  wire logic                  wake_condition_i,
  output logic                       stop_release_o
);
  // register bytes and the latch are one byte wide; other widths are not served
  if (SCAN_WIDTH != 8) begin : g_bad_width
    $error("scan port must be 8 bits");
  end

  logic [7:0] scan_latch;
  logic [7:0] ctrl;
  logic       ack;
  logic [7:0] rd_byte;
  logic [7:0] status;

  wire req      = cyc_i && stb_i && !ack;
  wire wr_lane0 = req && we_i && sel_i[0];
  wire hit_scan = adr_i == KSP_OFF_SCAN;
  wire hit_stat = adr_i == KSP_OFF_STATUS;
  wire hit_ctrl = adr_i == KSP_OFF_CTRL;
  wire scan_out = ctrl[KSP_B_SCAN_OUT];
  wire ind_out  = ctrl[KSP_B_IND_OUT];
  wire wake_en  = ctrl[KSP_B_WAKE_EN];
  wire s0_in    = ctrl[KSP_B_S0_MODE];
  wire s3_in    = HAS_SECOND_SENSE && ctrl[KSP_B_S3_MODE];

  // status write is dropped: no decode term for it
  wire wr_scan = wr_lane0 && hit_scan; // R3 R22
  wire wr_ctrl = wr_lane0 && hit_ctrl;
  // without the second sense pin its control bits stay zero
  wire [7:0] ctrl_wmask = HAS_SECOND_SENSE ? 8'hff : 8'h3f;

  ksp_status_mux #(
    .HAS_SECOND_SENSE(HAS_SECOND_SENSE)
  ) u_status (
    .pins_i  (pins_i),
    .ctrl_i  (ctrl),
    .status_o(status)
  );

  wire [7:0] scan_rd = scan_out ? scan_latch : scan_in_i; // R2
  assign rd_byte = hit_scan ? scan_rd :
                   hit_stat ? status :   // R19
                   hit_ctrl ? ctrl : 8'h00;

  always_ff @(posedge ref_clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      scan_latch <= KSP_SCAN_RESET; // R4
      ctrl       <= KSP_CTRL_RESET; // R21 R12 R15
    end else begin
      if (wr_scan) scan_latch <= dat_i[7:0]; // R3
      if (wr_ctrl) ctrl <= dat_i[7:0] & ctrl_wmask;
    end
  end

  always_ff @(posedge ref_clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      ack   <= 1'b0;
      dat_o <= 32'h0000_0000;
    end else begin
      ack <= req;
      if (req && !we_i) dat_o <= {24'h00_0000, rd_byte};
    end
  end
  assign ack_o = ack;

  // pin drive and pulls
  assign scan_oe_o  = {SCAN_WIDTH{scan_out}};   // R1
  assign scan_out_o = scan_latch;
  assign scan_pd_o  = {SCAN_WIDTH{!scan_out}};  // R5
  assign indicator_oe_o  = ind_out;             // R10
  // timer display drives the pin; idle high so reset shows a high level
  assign indicator_out_o = tx_display_i;        // R11 R12
  assign first_sense_in_en_o  = s0_in;          // R8
  assign second_sense_in_en_o = s3_in;          // R16 R17
  assign pulls_o.key          = {4{ctrl[KSP_B_KEY_PD]}}; // R7
  assign pulls_o.first_sense  = ctrl[KSP_B_S01_PD] && s0_in;  // R9
  assign pulls_o.indicator    = ctrl[KSP_B_S01_PD] && !ind_out; // R9 R11
  assign pulls_o.wake         = wake_en;        // R13 R14
  assign pulls_o.second_sense = s3_in && ctrl[KSP_B_S3_PD]; // R16
  // wake condition only counts while enabled
  assign stop_release_o = wake_en && wake_condition_i; // R13 R14

  a_scan_reset: assert property (@(posedge ref_clk_i) $rose(nrst_i) |->
    scan_oe_o == 8'hff && scan_out_o == 8'hff) else $error("scan reset wrong"); // R4
  a_scan_read: assert property (@(posedge ref_clk_i) disable iff (!nrst_i)
    req && !we_i && hit_scan && !scan_out |=> dat_o[7:0] == $past(scan_in_i))
    else $error("scan input read wrong"); // R2
  a_scan_write: assert property (@(posedge ref_clk_i) disable iff (!nrst_i)
    wr_scan |=> scan_latch == $past(dat_i[7:0])) else $error("latch not written"); // R3
  a_scan_pull: assert property (@(posedge ref_clk_i) disable iff (!nrst_i)
    !(scan_pd_o[0] && scan_oe_o[0])) else $error("pull while driving"); // R5
  a_status_ro: assert property (@(posedge ref_clk_i) disable iff (!nrst_i)
    req && we_i && hit_stat |=> $stable(ctrl) && $stable(scan_latch))
    else $error("status write had effect"); // R22
  a_s0_off_one: assert property (@(posedge ref_clk_i) disable iff (!nrst_i)
    !s0_in |-> status[KSP_B_ST_S0] && !pulls_o.first_sense)
    else $error("first sense off wrong"); // R8
  a_ind_pull: assert property (@(posedge ref_clk_i) disable iff (!nrst_i)
    indicator_oe_o |-> !pulls_o.indicator) else $error("indicator pull on output"); // R11
  a_wake_gate: assert property (@(posedge ref_clk_i) disable iff (!nrst_i)
    stop_release_o |-> wake_en && pulls_o.wake) else $error("wake not gated"); // R13
  a_s3_off_zero: assert property (@(posedge ref_clk_i) disable iff (!nrst_i)
    HAS_SECOND_SENSE && !ctrl[KSP_B_S3_MODE] |-> !status[KSP_B_ST_S3])
    else $error("second sense off not zero"); // R17
  a_ctrl_reset: assert property (@(posedge ref_clk_i) $rose(nrst_i) |->
    ctrl == 8'h26 && pulls_o.key == 4'hf) else $error("control reset wrong"); // R21
endmodule : ksp_ports
`default_nettype wire

// file: sim/ksp_keys_model.sv
// Purpose: key matrix and indicator wiring seen from the pins
// Assumes: pressed keys pull a line high, pull-downs win otherwise
// Notes: an unpulled, undriven scan line shows the inverse of the latch
`default_nettype none
module ksp_keys_model (
  input  wire logic       nrst_i,
  input  wire logic [7:0] scan_out_i,
  input  wire logic [7:0] scan_oe_i,
  input  wire logic [7:0] scan_pd_i,
  input  wire logic [7:0] press_i,
  input  wire logic [3:0] key_i,
  input  wire logic       ind_oe_i,
  input  wire logic       ind_out_i,
  input  wire logic       ind_ext_i,
  output logic [7:0]      scan_in_o,
  output logic [3:0]      key_o,
  output logic            ind_o
);
  timeunit 1ns;
  timeprecision 1ps;
  assign scan_in_o = (scan_oe_i & scan_out_i) |
                     (~scan_oe_i & (press_i | (~scan_pd_i & ~scan_out_i)));
  // key 0 held low while power-on clear is active
  assign key_o = {key_i[3:1], key_i[0] & nrst_i};
  assign ind_o = ind_oe_i ? ind_out_i : ind_ext_i;
endmodule : ksp_keys_model
`default_nettype wire

// file: sim/testbench.sv
// Purpose: register and pin checks of the key-scan and sense ports
// Assumes: ack within a few cycles of each request
// Notes: sequence of bus calls with pin expectations
`default_nettype none
module testbench;
  timeunit 1ns;
  timeprecision 1ps;
  import ksp_pkg::*;
  logic ref_clk_i, nrst_i, cyc, stb, we, tx, wk, wcond, fs, ss, ind_ext, ind_m;
  logic [3:0] adr, key_r, key_m;
  logic [31:0] dat, dat_o, q;
  logic [7:0] scan_in, scan_out, scan_oe, scan_pd, press;
  logic ack, ind_out, ind_oe, fs_en, ss_en, stop_rel;
  ksp_pulls_type pulls;
  int mismatches, cmp_count, cyc_cnt;
  ksp_pins_type pins;
  assign pins = {key_m, fs, ind_m, wk, ss};
  ksp_ports i_dut (.ref_clk_i(ref_clk_i), .nrst_i(nrst_i), .cyc_i(cyc), .stb_i(stb),
    .we_i(we), .adr_i(adr), .sel_i(4'hf), .dat_i(dat), .dat_o(dat_o), .ack_o(ack),
    .scan_in_i(scan_in), .scan_out_o(scan_out), .scan_oe_o(scan_oe), .scan_pd_o(scan_pd),
    .pins_i(pins), .pulls_o(pulls), .tx_display_i(tx), .indicator_out_o(ind_out),
    .indicator_oe_o(ind_oe), .first_sense_in_en_o(fs_en), .second_sense_in_en_o(ss_en),
    .wake_condition_i(wcond), .stop_release_o(stop_rel));
  ksp_keys_model i_keys (.nrst_i(nrst_i), .scan_out_i(scan_out), .scan_oe_i(scan_oe),
    .scan_pd_i(scan_pd), .press_i(press), .key_i(key_r), .ind_oe_i(ind_oe),
    .ind_out_i(ind_out), .ind_ext_i(ind_ext), .scan_in_o(scan_in), .key_o(key_m),
    .ind_o(ind_m));
  initial begin
    ref_clk_i = 1'b0;
    forever #5 ref_clk_i = ~ref_clk_i;
  end
  task automatic wb(input logic w, input logic [3:0] a, input logic [7:0] d);
    @(posedge ref_clk_i);
    cyc <= 1'b1; stb <= 1'b1; we <= w; adr <= a; dat <= {24'h0, d};
    do @(posedge ref_clk_i); while (ack !== 1'b1);
    q = dat_o;
    cyc <= 1'b0; stb <= 1'b0; we <= 1'b0;
  endtask : wb
  task automatic chk(input string n, input logic [31:0] e, input logic [31:0] g);
    cmp_count++;
    if (g !== e) begin
      mismatches++;
      $display("[ERR] %s expected %h seen %h", n, e, g);
    end
  endtask : chk
  task automatic complete_run;
    $display("comparisons %0d mismatches %0d", cmp_count, mismatches);
    if (mismatches == 0 && cmp_count > 0) $display("NO MISMATCHES");
    else $display("MISMATCHES SEEN");
    $finish;
  endtask : complete_run
  always @(posedge ref_clk_i) begin
    cyc_cnt++;
    if (cyc_cnt == 3000) begin
      mismatches++;
      complete_run();
    end
  end
  initial begin
    {cyc, stb, we, adr, dat, wcond, fs, ind_ext} = '0;
    ss = 1'b1;
    {nrst_i, tx, wk} = 3'b011; key_r = 4'ha; press = 8'h21;
    repeat (10) @(posedge ref_clk_i);
    nrst_i <= 1'b1;
    chk("oe", {scan_oe, pulls, ind_oe, fs_en, ss_en}, {8'hff, 8'hf0, 3'b100});
    wb(0, KSP_OFF_SCAN, 0); chk("scan", 32'hff, q);
    wb(0, KSP_OFF_CTRL, 0); chk("ctrl", 32'h26, q);
    wb(0, KSP_OFF_STATUS, 0); chk("st", {key_r, 4'b1110}, q);
    wb(1, KSP_OFF_SCAN, 8'h5a); wb(0, KSP_OFF_SCAN, 0); chk("scan", 32'h5a, q);
    $display("reset and latch test done");
    wb(1, KSP_OFF_CTRL, 8'h81); wb(1, KSP_OFF_SCAN, 8'h3c);
    chk("lat", {scan_out, scan_oe, scan_pd}, 24'h3c00ff);
    chk("en", {ind_oe, fs_en, ss_en}, 3'b011);
    wb(0, KSP_OFF_SCAN, 0); chk("scan", {24'h0, press}, q);
    wb(0, KSP_OFF_STATUS, 0); chk("st", {key_r, 4'b0011}, q);
    chk("pd", pulls, 8'h00);
    $display("input mode test done");
    wcond <= 1'b1;
    wb(1, KSP_OFF_CTRL, 8'hd8); chk("pd", {stop_rel, pulls}, 9'h107);
    wb(1, KSP_OFF_CTRL, 8'h15); chk("pd", {stop_rel, pulls}, 9'h008);
    chk("ind", {ind_oe, ind_out, fs_en, ss_en}, 4'b1110);
    wb(0, KSP_OFF_STATUS, 0); chk("st", {key_r, 4'b1010}, q);
    wb(1, KSP_OFF_STATUS, 8'h00); wb(0, KSP_OFF_CTRL, 0); chk("ctrl", 32'h15, q);
    chk("lat", scan_out, 8'h3c);
    wb(0, 4'hc, 0); chk("unmap", 32'h0, q);
    $display("pull and wake test done");
    complete_run();
  end
endmodule : testbench
`default_nettype wire
